// ### design/tas_alu.sv
/*
  combinational arithmetic for subtract with borrow, nibble swap and
  the zero test. assumes operands are stable from quarter 3 onward.
*/
`timescale 1ns/1ps
module tas_alu (
  // operands in, results out
  tas_alu_if.alu au
);

  // adds with the inverted subtrahend; carry out high means no borrow
  logic [8:0] full_sum;  // nine bit sum for carry
  logic [4:0] low_sum;   // five bit nibble sum for digit carry

  // two's complement subtract: f + ~w + c equals f - w - ~c
  always_comb begin
    full_sum = {1'b0, au.opnd_f} + {1'b0, ~au.opnd_w}
             + {8'h00, au.carry_in};                          // RQ12
    low_sum  = {1'b0, au.opnd_f[3:0]} + {1'b0, ~au.opnd_w[3:0]}
             + {4'h0, au.carry_in};
  end

  assign au.result  = full_sum[7:0];
  assign au.flag_c  = full_sum[8];
  assign au.flag_dc = low_sum[4];
  assign au.flag_z  = (full_sum[7:0] == 8'h00);
  // overflow only when signs differ and the result takes the w sign
  assign au.flag_ov = (au.opnd_f[7] != au.opnd_w[7])
                    && (full_sum[7] != au.opnd_f[7]);
  assign au.swapped = {au.opnd_f[3:0], au.opnd_f[7:4]};       // RQ1
  assign au.is_zero = (au.opnd_f == 8'h00);                   // RQ11

endmodule : tas_alu

// ### design/tas_alu_if.sv
/*
  carrier between the executor and its arithmetic unit.
  assumes both ends run on the executor's clock; the unit is purely
  combinational.
*/
`timescale 1ns/1ps
interface tas_alu_if;
  logic [7:0] opnd_f;    // file register operand
  logic [7:0] opnd_w;    // working_register operand
  logic       carry_in;  // carry flag before the operation
  logic [7:0] result;    // difference with borrow
  logic [7:0] swapped;   // nibble exchanged operand
  logic       is_zero;   // file operand equals zero
  logic       flag_ov;   // signed overflow
  logic       flag_c;    // carry, high means no borrow
  logic       flag_dc;   // digit carry out of the low nibble
  logic       flag_z;    // result equals zero

  modport core (output opnd_f, opnd_w, carry_in,
                input  result, swapped, is_zero,
                       flag_ov, flag_c, flag_dc, flag_z);
  modport alu  (input  opnd_f, opnd_w, carry_in,
                output result, swapped, is_zero,
                       flag_ov, flag_c, flag_dc, flag_z);
endinterface : tas_alu_if

// ### design/tas_exec.sv
/*
  execution logic for subtract with borrow, nibble swap, zero test and
  table transfers through the 16 bit table latch and table pointer.
  assumes the decoder holds op and operands while instr_valid is high,
  file registers answer in the same clock, memory within the access cycle.
*/
// Summary of operation
// RQ1: swap writes the two nibbles exchanged, no flags
// RQ2: table read moves selected latch byte first
// RQ3: then loads latch from memory at pointer
// RQ4: increment operand advances pointer after access
// RQ5: table read two cycles, three to pc low
// RQ6: latch byte read quarter two, written quarter four
// RQ7: latch read copies selected byte, one cycle
// RQ8: latch read leaves latch and pointer alone
// RQ9: latch write loads selected latch byte, one cycle
// RQ10: table write loads latch byte in quarter four
// RQ11: zero test discards next instruction when zero
// RQ12: subtract borrow result to w or f, flags
// RQ13: table write stores latch, then optional increment
`timescale 1ns/1ps
module tas_exec #(
  parameter logic [7:0] PCL_ADDR = tas_pkg::PCL_ADDR_DFLT  // pc low byte
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // decoded instruction from the core
  input  wire logic        instr_valid,
  input  wire logic [2:0]  instr_op,
  input  wire logic [7:0]  instr_f,
  input  wire logic        instr_d,
  input  wire logic        instr_t,
  input  wire logic        instr_i,
  output logic             instr_ready,
  // core state inputs and the file register read address
  input  wire logic [7:0]  working_register,
  input  wire logic        carry_flag,
  input  wire logic [7:0]  file_rdata,
  output logic [7:0]       file_raddr,
  // pointer load from other instructions
  input  wire logic        ptr_load,
  input  wire logic [15:0] ptr_load_data,
  // result writes
  output logic             file_we,
  output logic [7:0]       file_waddr,
  output logic [7:0]       file_wdata,
  output logic             working_register_we,
  output logic [7:0]       working_register_wdata,
  output logic             flags_we,
  output logic [3:0]       flags_ovcdz,
  output logic             skip_next,
  // program memory port
  output logic [15:0]      pm_addr,
  output logic             pm_rd,
  input  wire logic [15:0] pm_rdata,
  output logic             pm_wr,
  output logic [15:0]      pm_wdata,
  // table state seen by the core
  output logic [15:0]      table_latch,
  output logic [15:0]      table_pointer,
  output logic             busy
);

  tas_pkg::tas_stage_e stage_ff;      // instruction cycle in progress
  tas_pkg::tas_stage_e nxt_stage;     // next stage
  logic [1:0]          qtr_ff;        // current quarter
  logic [2:0]          op_ff;         // latched operation
  logic [7:0]          f_ff;          // latched file address
  logic                d_ff;          // destination select
  logic                t_ff;          // byte select
  logic                i_ff;          // increment select
  logic [7:0]          src_ff;        // operand read in quarter 2
  logic [7:0]          w_ff;          // working_register read in q2
  logic                c_ff;          // carry read in quarter 2
  logic [15:0]         latch_ff;      // table_latch
  logic [15:0]         ptr_ff;        // table_pointer
  logic                take;          // instruction accepted this clock
  logic                is_table;      // two cycle table transfer
  tas_alu_if           au ();         // arithmetic carrier

  // pick one byte of a word; used for the latch read back path and the checks
  function automatic logic [7:0] byte_sel(input logic [15:0] w,
                                          input logic hi);
    byte_sel = hi ? w[15:8] : w[7:0];
  endfunction : byte_sel
  tas_alu u_alu (
    .au (au.alu)
  );
  assign au.opnd_f   = src_ff;
  assign au.opnd_w   = w_ff;
  assign au.carry_in = c_ff;

  // only take an instruction at a decode quarter when idle
  assign instr_ready = (stage_ff == tas_pkg::TAS_IDLE)
                     && (qtr_ff == tas_pkg::QTR_1);
  assign take        = instr_ready && instr_valid;
  assign is_table    = (op_ff == tas_pkg::OP_TBLRD)
                     || (op_ff == tas_pkg::OP_TBLWT);
  assign busy        = (stage_ff != tas_pkg::TAS_IDLE);
  assign file_raddr  = f_ff;
  assign table_latch   = latch_ff;
  assign table_pointer = ptr_ff;
  assign pm_addr     = ptr_ff;
  assign pm_wdata    = latch_ff;
  // read strobe stands for the whole access cycle of a table read
  assign pm_rd = (stage_ff == tas_pkg::TAS_CYC2)
               && (op_ff == tas_pkg::OP_TBLRD);

  // quarter counter runs free; every instruction cycle is four clocks
  always_ff @(posedge core_clk) begin
    if (sys_rst) qtr_ff <= tas_pkg::QTR_1;
    else         qtr_ff <= qtr_ff + 2'h1;
  end

  // stage sequencing, leaves idle at the end of a decode quarter, else advances at the end of each fourth quarter
  always_comb begin
    nxt_stage = stage_ff;
    unique case (stage_ff)
      tas_pkg::TAS_IDLE: if (take) nxt_stage = tas_pkg::TAS_CYC1;
      tas_pkg::TAS_CYC1: if (qtr_ff == tas_pkg::QTR_4)
        nxt_stage = is_table ? tas_pkg::TAS_CYC2           // RQ5
                             : tas_pkg::TAS_IDLE;
      tas_pkg::TAS_CYC2: if (qtr_ff == tas_pkg::QTR_4)
        // writing pc low costs one more cycle to refetch
        nxt_stage = (op_ff == tas_pkg::OP_TBLRD && f_ff == PCL_ADDR)
                  ? tas_pkg::TAS_CYC3 : tas_pkg::TAS_IDLE;  // RQ5
      tas_pkg::TAS_CYC3: if (qtr_ff == tas_pkg::QTR_4)
        nxt_stage = tas_pkg::TAS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) stage_ff <= tas_pkg::TAS_IDLE;
    else         stage_ff <= nxt_stage;
  end

  // operand capture at decode; held for the whole instruction
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      op_ff <= tas_pkg::OP_SUBB;
      f_ff  <= 8'h00;
      d_ff  <= 1'b0;
      t_ff  <= 1'b0;
      i_ff  <= 1'b0;
    end else if (take) begin
      op_ff <= instr_op;
      f_ff  <= instr_f;
      d_ff  <= instr_d;
      t_ff  <= instr_t;
      i_ff  <= instr_i;
    end
  end

  // quarter 2 read: a latch byte for reads, else the file register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      src_ff <= 8'h00;
      w_ff   <= 8'h00;
      c_ff   <= 1'b0;
    end else if (stage_ff == tas_pkg::TAS_CYC1
                 && qtr_ff == tas_pkg::QTR_2) begin
      if (op_ff == tas_pkg::OP_TBLRD || op_ff == tas_pkg::OP_LATCH_READ_OP)
        src_ff <= byte_sel(latch_ff, t_ff);                   // RQ6
      else
        src_ff <= file_rdata;                                  // RQ10
      w_ff <= working_register;
      c_ff <= carry_flag;
    end
  end

  // result strobes stand for the fourth quarter of the first cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      file_we     <= 1'b0;
      working_register_we     <= 1'b0;
      flags_we    <= 1'b0;
      skip_next   <= 1'b0;
      file_waddr  <= 8'h00;
      file_wdata  <= 8'h00;
      working_register_wdata  <= 8'h00;
      flags_ovcdz <= 4'h0;
    end else begin
      file_we   <= 1'b0;
      working_register_we   <= 1'b0;
      flags_we  <= 1'b0;
      skip_next <= 1'b0;
      if (stage_ff == tas_pkg::TAS_CYC1 && qtr_ff == tas_pkg::QTR_3) begin
        file_waddr <= f_ff;
        unique case (op_ff)
          tas_pkg::OP_SUBB: begin
            file_we     <= d_ff;                               // RQ12
            working_register_we     <= ~d_ff;
            file_wdata  <= au.result;
            working_register_wdata  <= au.result;
            flags_we    <= 1'b1;
            flags_ovcdz <= {au.flag_ov, au.flag_c, au.flag_dc, au.flag_z};
          end
          tas_pkg::OP_SWAP: begin
            // flags left alone on purpose
            file_we    <= d_ff;                                // RQ1
            working_register_we    <= ~d_ff;
            file_wdata <= au.swapped;
            working_register_wdata <= au.swapped;
          end
          tas_pkg::OP_TSTZ: skip_next <= au.is_zero;           // RQ11
          tas_pkg::OP_TBLRD, tas_pkg::OP_LATCH_READ_OP: begin
            file_we    <= 1'b1;                                // RQ2 RQ7
            file_wdata <= src_ff;
          end
          default: ;  // latch writes touch no file register
        endcase
      end
    end
  end

  // memory write strobe: one clock in quarter 2 of the access cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) pm_wr <= 1'b0;
    else pm_wr <= (stage_ff == tas_pkg::TAS_CYC2)
               && (qtr_ff == tas_pkg::QTR_1)
               && (op_ff == tas_pkg::OP_TBLWT);                // RQ13
  end

  // table latch: byte loads end quarter 4, word load ends access cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) latch_ff <= tas_pkg::LATCH_RST;
    else if (qtr_ff == tas_pkg::QTR_4) begin
      if (stage_ff == tas_pkg::TAS_CYC1
          && (op_ff == tas_pkg::OP_LATCH_WRITE_OP || op_ff == tas_pkg::OP_TBLWT)) begin
        if (t_ff) latch_ff[15:8] <= src_ff;                    // RQ9 RQ10
        else      latch_ff[7:0]  <= src_ff;
      end else if (stage_ff == tas_pkg::TAS_CYC2
                   && op_ff == tas_pkg::OP_TBLRD) begin
        latch_ff <= pm_rdata;                                  // RQ3
      end
    end
  end

  // table pointer: a core load wins over an instruction increment
  always_ff @(posedge core_clk) begin
    if (sys_rst) ptr_ff <= tas_pkg::PTR_RST;
    else if (ptr_load) ptr_ff <= ptr_load_data;
    else if (stage_ff == tas_pkg::TAS_CYC2 && qtr_ff == tas_pkg::QTR_4
             && i_ff) begin
      ptr_ff <= ptr_ff + 16'h0001;                             // RQ4 RQ13
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  chk_swap_nibbles: assert property (                          // RQ1
    (op_ff == tas_pkg::OP_SWAP && (file_we || working_register_we))
      |-> !flags_we && file_wdata[7:4] == src_ff[3:0]
          && file_wdata[3:0] == src_ff[7:4])
    else $error("swap result or flags wrong");
  chk_rd_byte_move: assert property (                          // RQ2
    (stage_ff == tas_pkg::TAS_CYC1 && qtr_ff == tas_pkg::QTR_4
     && op_ff == tas_pkg::OP_TBLRD)
      |-> file_we && file_wdata == byte_sel(latch_ff, t_ff))
    else $error("table read moved wrong latch byte");
  chk_rd_latch_load: assert property (                         // RQ3
    (pm_rd && qtr_ff == tas_pkg::QTR_4)
      |=> latch_ff == $past(pm_rdata))
    else $error("latch not loaded from memory");
  chk_ptr_step: assert property (                              // RQ4
    (stage_ff == tas_pkg::TAS_CYC2 && qtr_ff == tas_pkg::QTR_4
     && !ptr_load)
      |=> ptr_ff == $past(ptr_ff) + {15'h0000, $past(i_ff)})
    else $error("pointer step wrong");
  chk_rd_two_cycles: assert property (                         // RQ5
    (take && instr_op == tas_pkg::OP_TBLRD && instr_f != PCL_ADDR)
      |=> busy [*7] ##1 !busy)
    else $error("table read not two cycles");
  chk_rd_pcl_three: assert property (                          // RQ5
    (take && instr_op == tas_pkg::OP_TBLRD && instr_f == PCL_ADDR)
      |=> busy [*8] ##1 busy [*3] ##1 !busy)
    else $error("table read to pc low not three cycles");
  chk_latch_read_op_keeps: assert property (                            // RQ8
    (stage_ff == tas_pkg::TAS_CYC1 && op_ff == tas_pkg::OP_LATCH_READ_OP
     && !ptr_load)
      |=> $stable(latch_ff) && $stable(ptr_ff))
    else $error("latch read changed table state");
  chk_latch_write_op_byte: assert property (                             // RQ9
    (stage_ff == tas_pkg::TAS_CYC1 && qtr_ff == tas_pkg::QTR_4
     && op_ff == tas_pkg::OP_LATCH_WRITE_OP)
      |=> byte_sel(latch_ff, $past(t_ff)) == $past(src_ff) && !busy)
    else $error("latch write byte wrong");
  chk_skip_zero: assert property (                             // RQ11
    skip_next |-> op_ff == tas_pkg::OP_TSTZ && src_ff == 8'h00)
    else $error("skip without zero operand");
  chk_wt_store: assert property (                              // RQ13
    pm_wr |-> pm_wdata == latch_ff && pm_addr == ptr_ff
              && stage_ff == tas_pkg::TAS_CYC2 && qtr_ff == tas_pkg::QTR_2
              && op_ff == tas_pkg::OP_TBLWT)
    else $error("table write stored wrong word");
endmodule : tas_exec

// ### design/tas_pkg.sv
/*
  shared constants for the table access and alu instruction subset:
  quarter numbering, operation codes, widths and reset values.
  assumes every user refers to names as tas_pkg::name.
*/
package tas_pkg;

  // widths
  localparam int DATA_W  = 8;   // data path and file register width
  localparam int WORD_W  = 16;  // program memory word, latch and pointer
  localparam int ADDR_W  = 8;   // file register address width

  // quarter numbering inside one instruction cycle
  localparam logic [1:0] QTR_1 = 2'h0;  // decode
  localparam logic [1:0] QTR_2 = 2'h1;  // read operand
  localparam logic [1:0] QTR_3 = 2'h2;  // execute
  localparam logic [1:0] QTR_4 = 2'h3;  // write result

  // operation codes presented by the core's decoder
  localparam logic [2:0] OP_SUBB  = 3'h0;  // subtract_borrow_op
  localparam logic [2:0] OP_SWAP  = 3'h1;  // nibble_swap_op
  localparam logic [2:0] OP_TSTZ  = 3'h2;  // test_skip_zero_op
  localparam logic [2:0] OP_TBLRD = 3'h3;  // table_read_op
  localparam logic [2:0] OP_TBLWT = 3'h4;  // table_write_op
  localparam logic [2:0] OP_LATCH_READ_OP  = 3'h5;  // latch_read_op
  localparam logic [2:0] OP_LATCH_WRITE_OP  = 3'h6;  // latch_write_op

  // reset values and the default pc low address
  localparam logic [WORD_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [WORD_W-1:0] PTR_RST   = 16'h0000;
  localparam logic [ADDR_W-1:0] PCL_ADDR_DFLT = 8'h02;

  // instruction cycle sequencing
  typedef enum logic [1:0] {
    TAS_IDLE,   // waiting for a decode quarter
    TAS_CYC1,   // first instruction cycle, quarters 2 to 4
    TAS_CYC2,   // memory access cycle of a table transfer
    TAS_CYC3    // extra cycle when a table read targets the pc low byte
  } tas_stage_e;

endpackage : tas_pkg

// ### tb/tas_exec_tb.sv
/*
  self-checking bench for the table access and alu executor.
  assumes the executor, its alu and the memory model are compiled first.
*/
`timescale 1ns/1ps
module tas_exec_tb;
  localparam logic [7:0] PROGRAM_COUNTER_LOW = tas_pkg::PCL_ADDR_DFLT;  // pc low byte
  // stimulus and results
  logic        core_clk, sys_rst, instr_valid, instr_d, instr_t, instr_i;
  logic [2:0]  instr_op;
  logic [7:0]  instr_f, working_register, file_rdata, file_raddr;
  logic        carry_flag, ptr_load, instr_ready, busy;
  logic [15:0] ptr_load_data, pm_addr, pm_rdata, pm_wdata;
  logic        file_we, working_register_we, flags_we, skip_next, pm_rd, pm_wr;
  logic [7:0]  file_waddr, file_wdata, working_register_wdata;
  logic [3:0]  flags_ovcdz;
  logic [15:0] table_latch, table_pointer;
  // what one instruction produced
  int          n_fwe, n_wwe, n_flg, n_skp, n_wr, n_rd, len;
  logic [7:0]  o_fa, o_fd, o_wd;
  logic [3:0]  o_flg;
  logic [15:0] o_pa, o_pd;
  int          bad_count, tests_run;
  int          cyc_cnt = 0;  // clocks since start, owned by the hang guard

  tas_exec #(.PCL_ADDR(PROGRAM_COUNTER_LOW)) u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_f(instr_f), .instr_d(instr_d),
    .instr_t(instr_t), .instr_i(instr_i), .instr_ready(instr_ready),
    .working_register(working_register), .carry_flag(carry_flag),
    .file_rdata(file_rdata), .file_raddr(file_raddr),
    .ptr_load(ptr_load), .ptr_load_data(ptr_load_data),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .working_register_we(working_register_we), .working_register_wdata(working_register_wdata), .flags_we(flags_we),
    .flags_ovcdz(flags_ovcdz), .skip_next(skip_next), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_rdata(pm_rdata), .pm_wr(pm_wr),
    .pm_wdata(pm_wdata), .table_latch(table_latch),
    .table_pointer(table_pointer), .busy(busy));

  tas_pm_model u_pm (
    .core_clk(core_clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_wr(pm_wr), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata));

  // free running clock, 10 ns period
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // counts, verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  // hang guard, far above the roughly one hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic cmp8(input string nm, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8

  task automatic cmp16(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp16

  // offer one instruction at a quarter 1, then record until idle again;
  // entered and left on a falling edge
  task automatic issue(input logic [2:0] op, input logic [7:0] f,
                       input logic d, t, i, input logic [7:0] fv, w,
                       input logic c);
    int k;
    k = 0;
    while (instr_ready !== 1'b1 && k < 16) begin
      @(negedge core_clk);
      k++;
    end
    {instr_valid, instr_op, instr_f, instr_d, instr_t} = {1'b1, op, f, d, t};
    {instr_i, file_rdata, working_register, carry_flag} = {i, fv, w, c};
    @(posedge core_clk);
    @(negedge core_clk);
    instr_valid = 1'b0;
    {n_fwe, n_wwe, n_flg, n_skp, n_wr, n_rd, len} = '0;
    {o_fa, o_fd, o_wd, o_flg, o_pa, o_pd} = 'x;
    // the decode clock has already passed and belongs to the instruction
    len = 1;
    // strobes other than pm_rd stand one clock, so every clock is looked at
    do begin
      len++;
      if (file_we === 1'b1)
        {n_fwe, o_fa, o_fd} = {n_fwe + 1, file_waddr, file_wdata};
      if (working_register_we === 1'b1) {n_wwe, o_wd} = {n_wwe + 1, working_register_wdata};
      if (flags_we === 1'b1) {n_flg, o_flg} = {n_flg + 1, flags_ovcdz};
      if (skip_next === 1'b1) n_skp++;
      if (pm_rd === 1'b1) n_rd++;
      if (pm_wr === 1'b1) {n_wr, o_pa, o_pd} = {n_wr + 1, pm_addr, pm_wdata};
      @(negedge core_clk);
    end while (instr_ready !== 1'b1 && len < 16);
  endtask : issue

  // pointer load pulse between instructions
  task automatic load_ptr(input logic [15:0] v);
    {ptr_load, ptr_load_data} = {1'b1, v};
    @(negedge core_clk);
    ptr_load = 1'b0;
    cmp16("pointer load", v, table_pointer);
  endtask : load_ptr

  // own reference in plain integers: {ov, c, dc, z, result}
  // carry means no borrow, overflow means the signed difference left range
  function automatic logic [11:0] sub_ref(input logic [7:0] f, w,
                                          input logic c);
    int r;
    int h;
    int s;
    r = int'(f) - int'(w) - int'(!c);
    h = int'(f[3:0]) - int'(w[3:0]) - int'(!c);
    s = int'($signed(f)) - int'($signed(w)) - int'(!c);
    return {(s < -128) || (s > 127), r >= 0, h >= 0,
            r[7:0] == 8'h00, r[7:0]};
  endfunction : sub_ref

  task automatic t_swap();
    issue(tas_pkg::OP_SWAP, 8'h31, 1'b1, 1'b0, 1'b0, 8'h53, 8'h00, 1'b0);
    cmp8("swap file data", 8'h35, o_fd);
    cmp8("swap file addr", 8'h31, o_fa);
    cmp8("swap read addr", 8'h31, file_raddr);
    cmp8("swap flag writes", 8'h00, 8'(n_flg));
    issue(tas_pkg::OP_SWAP, 8'h31, 1'b0, 1'b0, 1'b0, 8'hc7, 8'h00, 1'b1);
    cmp8("swap working_register data", 8'h7c, o_wd);
    cmp8("swap file writes", 8'h00, 8'(n_fwe));
    $display("test swap done");
  endtask : t_swap

  task automatic t_subb();
    logic [7:0]  fv [5];
    logic [7:0]  wv [5];
    logic [4:0]  cv;
    logic [11:0] e;
    fv = '{8'h19, 8'h1b, 8'h03, 8'h80, 8'h00};
    wv = '{8'h0d, 8'h1a, 8'h0e, 8'h01, 8'h00};
    // first three pairs carry the borrow-in of the worked examples
    cv = 5'b10101;
    for (int k = 0; k < 5; k++) begin
      e = sub_ref(fv[k], wv[k], cv[4-k]);
      issue(tas_pkg::OP_SUBB, 8'h22, k[0], 1'b0, 1'b0, fv[k], wv[k],
            cv[4-k]);
      // odd entries go to the file register, even ones to w
      cmp8("sub result", e[7:0], k[0] ? o_fd : o_wd);
      cmp8("sub flags", {4'h0, e[11:8]}, {4'h0, o_flg});
      cmp8("sub flag writes", 8'h01, 8'(n_flg));
      cmp8("sub w writes", {7'h00, ~k[0]}, 8'(n_wwe));
    end
    $display("test subtract done");
  endtask : t_subb

  task automatic t_tstz();
    issue(tas_pkg::OP_TSTZ, 8'h23, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    cmp8("skip on zero", 8'h01, 8'(n_skp));
    cmp8("test length", 8'h04, 8'(len));
    issue(tas_pkg::OP_TSTZ, 8'h23, 1'b0, 1'b0, 1'b0, 8'h05, 8'h00, 1'b0);
    cmp8("skip on nonzero", 8'h00, 8'(n_skp));
    $display("test zero skip done");
  endtask : t_tstz

  task automatic t_latch();
    issue(tas_pkg::OP_LATCH_WRITE_OP, 8'h24, 1'b0, 1'b0, 1'b0, 8'hb7, 8'h00, 1'b0);
    issue(tas_pkg::OP_LATCH_WRITE_OP, 8'h24, 1'b0, 1'b1, 1'b0, 8'h12, 8'h00, 1'b0);
    cmp16("latch after writes", 16'h12b7, table_latch);
    cmp8("latch write length", 8'h04, 8'(len));
    issue(tas_pkg::OP_LATCH_READ_OP, 8'h25, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0);
    cmp8("latch read high", 8'h12, o_fd);
    cmp8("latch read length", 8'h04, 8'(len));
    issue(tas_pkg::OP_LATCH_READ_OP, 8'h26, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 1'b0);
    cmp8("latch read low", 8'hb7, o_fd);
    cmp16("latch kept", 16'h12b7, table_latch);
    cmp16("pointer kept", 16'h0000, table_pointer);
    $display("test latch done");
  endtask : t_latch

  task automatic t_tblwt();
    load_ptr(16'h0056);
    issue(tas_pkg::OP_TBLWT, 8'h27, 1'b0, 1'b1, 1'b1, 8'h53, 8'h00, 1'b0);
    cmp16("write latch", 16'h53b7, table_latch);
    cmp16("write word", 16'h53b7, o_pd);
    cmp16("write addr", 16'h0056, o_pa);
    cmp8("write pulses", 8'h01, 8'(n_wr));
    cmp16("write ptr inc", 16'h0057, table_pointer);
    cmp8("write length", 8'h08, 8'(len));
    issue(tas_pkg::OP_TBLWT, 8'h27, 1'b0, 1'b0, 1'b0, 8'haa, 8'h00, 1'b0);
    cmp16("write word low", 16'h53aa, o_pd);
    cmp16("write ptr held", 16'h0057, table_pointer);
    $display("test table write done");
  endtask : t_tblwt

  task automatic t_tblrd();
    load_ptr(16'h0056);
    issue(tas_pkg::OP_TBLRD, 8'h40, 1'b0, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0);
    cmp8("read old high", 8'h53, o_fd);
    cmp8("read dest", 8'h40, o_fa);
    cmp16("read latch load", 16'h53b7, table_latch);
    cmp16("read ptr inc", 16'h0057, table_pointer);
    cmp8("read length", 8'h08, 8'(len));
    cmp8("read strobe clocks", 8'h04, 8'(n_rd));
    issue(tas_pkg::OP_TBLRD, PROGRAM_COUNTER_LOW, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
    cmp8("read old low", 8'hb7, o_fd);
    cmp16("read latch pcl", 16'h53aa, table_latch);
    cmp16("read ptr held", 16'h0057, table_pointer);
    cmp8("read pcl length", 8'h0c, 8'(len));
    $display("test table read done");
  endtask : t_tblrd

  // main sequence: reset for two clocks, then the tests back to back
  initial begin
    {sys_rst, instr_valid, instr_op, instr_f, instr_d} = {1'b1, 13'h0};
    {instr_t, instr_i, working_register, carry_flag} = '0;
    {file_rdata, ptr_load, ptr_load_data} = '0;
    {bad_count, tests_run} = '0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    cmp16("latch reset", tas_pkg::LATCH_RST, table_latch);
    cmp16("pointer reset", tas_pkg::PTR_RST, table_pointer);
    t_swap();
    t_subb();
    t_tstz();
    t_latch();
    t_tblwt();
    t_tblrd();
    wrap_up();
  end
endmodule : tas_exec_tb

// ### tb/tas_pm_model.sv
/*
  program memory model on the far side of the table port.
  assumes pm_rd and pm_wr are driven by the executor on core_clk.
*/
`timescale 1ns/1ps
module tas_pm_model (
  // clock
  input  wire logic        core_clk,
  // access port
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_rd,
  input  wire logic        pm_wr,
  input  wire logic [15:0] pm_wdata,
  output logic      [15:0] pm_rdata
);
  logic [15:0] mem [256];  // small window, upper address bits ignored
  logic [15:0] last_q;     // last word seen on the data lines
  // preset so every word differs from its neighbours
  initial begin
    for (int k = 0; k < 256; k++) mem[k] = {8'hc3 ^ k[7:0], k[7:0]};
    last_q = 16'h0000;
  end
  // whole word stored on the write pulse
  always @(posedge core_clk) begin
    if (pm_wr) mem[pm_addr[7:0]] <= pm_wdata;
    last_q <= pm_rdata;
  end
  // idle lines flip every clock so a stale word is never taken
  assign pm_rdata = pm_rd ? mem[pm_addr[7:0]] : ~last_q;
endmodule : tas_pm_model
